// [core/pb_pkg.sv]
// constants and address decode shared by the power budget register block
// assumes a 12-bit configuration offset and 32-bit register words
package pb_pkg;

	// register byte offsets
	localparam logic [11:0] HEADER_OFFSET     = 12'h280;
	localparam logic [11:0] SELECT_OFFSET     = 12'h284;
	localparam logic [11:0] WINDOW_OFFSET     = 12'h288;
	localparam logic [11:0] ALLOC_OFFSET      = 12'h28c;
	localparam logic [11:0] VALUE_BASE_OFFSET = 12'h300;
	localparam logic [11:0] VALUE_LAST_OFFSET = 12'h31c;
	localparam logic [11:0] SWITCH_CTL_OFFSET = 12'h400;

	// header field positions
	localparam int IDENT_LSB    = 0;
	localparam int IDENT_MSB    = 15;
	localparam int VERSION_LSB  = 16;
	localparam int VERSION_MSB  = 19;
	localparam int NEXT_PTR_LSB = 20;
	localparam int NEXT_PTR_MSB = 31;

	// other field positions
	localparam int SELECT_MSB        = 7;
	localparam int ALLOC_FLAG_BIT    = 0;
	localparam int VALUE_UNLOCK_BIT  = 0;
	localparam int HEADER_UNLOCK_BIT = 1;

	// reset values
	localparam logic [15:0] IDENT_RESET    = 16'h0000;
	localparam logic [3:0]  VERSION_RESET  = 4'h0;
	localparam logic [11:0] NEXT_PTR_RESET = 12'h000;
	localparam logic [7:0]  SELECT_RESET = 8'h00;
	localparam logic        ALLOC_RESET  = 1'b0;
	localparam logic        UNLOCK_RESET = 1'b0;
	localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

	// value array shape
	localparam int          VALUE_COUNT  = 8;
	localparam logic [7:0]  SELECT_LAST  = 8'h07;

	// true when the offset falls on one of the eight value words
	function automatic logic is_value_addr(input logic [11:0] addr);
		is_value_addr = (addr >= VALUE_BASE_OFFSET) &&
			(addr <= VALUE_LAST_OFFSET) && (addr[1:0] == 2'b00);
	endfunction : is_value_addr

	// value word index from its offset
	function automatic logic [2:0] value_index(input logic [11:0] addr);
		logic [11:0] rel;
		rel = addr - VALUE_BASE_OFFSET;
		value_index = rel[4:2];
	endfunction : value_index

endpackage : pb_pkg

// [core/value_if.sv]
// carrier between the register front end and the value store
// assumes both ends run on the same pclk
interface value_if;
	logic        bus_we;
	logic        load_we;
	logic        unlock;
	logic [2:0]  idx;
	logic [31:0] wdata;
	logic [31:0] value [8];

	modport store_side (
		input  bus_we,
		input  load_we,
		input  unlock,
		input  idx,
		input  wdata,
		output value
	);
	modport reg_side (
		output bus_we,
		output load_we,
		output unlock,
		output idx,
		output wdata,
		input  value
	);
endinterface : value_if

// [core/value_store.sv]
// eight sticky 32-bit power budget data words
// assumes writes arrive already decoded to an index on pclk
module value_store (
	input wire logic   pclk,
	value_if.store_side vif
);

	// no reset on purpose: contents survive warm resets, undefined at power-up
	always_ff @(posedge pclk) begin
		if (vif.load_we || (vif.bus_we && vif.unlock)) begin
			vif.value[vif.idx] <= vif.wdata;
		end
	end

endmodule : value_store

// [core/power_budget_regs.sv]
// power budgeting capability register block with an apb slave
// assumes apb master and configuration loader share pclk and presetn
//
// Summary of operation
// - header bits 15:0 hold capability id, 0x4 means power budget, resets 0
// - header bits 19:16 hold capability version, 0x1 means 2.0
// - header bits 31:20 hold next pointer, zero ends the list
// - select register bits 7:0 read-write, bits 31:8 read zero
// - select above 7 makes the data window read zero
// - select 0 to 7 shows that value word in the read-only window
// - alloc register bit 0 says power already counted in system budget
// - value words writable over apb only while the value unlock bit is set; the loader writes them at any time
// - value unlock clear: apb writes to value words are dropped silently
// - eight value words at 0x300 to 0x31c, indexed by select
// - each value word holds one power budget entry, stored whole
module power_budget_regs (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        loader_we,
	input  wire logic [11:0] loader_addr,
	input  wire logic [31:0] loader_wdata,
	output logic             system_allocated_flag,
	output logic             value_write_unlock
);

	value_if vif ();

	logic [15:0] capability_identifier;
	logic [3:0]  capability_version;
	logic [11:0] next_capability_pointer;
	logic [7:0]  value_select_field;
	logic        header_write_unlock;
	logic        bus_wr;
	logic        wr_en;
	logic        wr_priv;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic        lock_open;
	logic [31:0] next_prdata;
	logic        next_err;
	logic [31:0] window_data;

	value_store u_store (
		.pclk (pclk),
		.vif  (vif.store_side)
	);

	// loader has priority; the bus is stalled rather than losing its write
	assign pready = ~loader_we;
	assign bus_wr = psel & penable & pwrite & ~loader_we;

	// one write port shared by the loader and the bus
	assign wr_en   = loader_we | bus_wr;
	assign wr_priv = loader_we;
	assign wr_addr = loader_we ? loader_addr : paddr;
	assign wr_data = loader_we ? loader_wdata : pwdata;
	assign lock_open = wr_priv | header_write_unlock;

	// value store write decode
	assign vif.bus_we  = bus_wr & pb_pkg::is_value_addr(paddr);
	assign vif.load_we = loader_we & pb_pkg::is_value_addr(loader_addr);
	assign vif.unlock  = value_write_unlock;
	assign vif.idx     = pb_pkg::value_index(wr_addr);
	assign vif.wdata   = wr_data;

	// header fields, locked against plain software writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capability_identifier   <= pb_pkg::IDENT_RESET;
			capability_version      <= pb_pkg::VERSION_RESET;
			next_capability_pointer <= pb_pkg::NEXT_PTR_RESET;
		end else if (wr_en && wr_addr == pb_pkg::HEADER_OFFSET &&
				lock_open) begin
			capability_identifier <=
				wr_data[pb_pkg::IDENT_MSB:pb_pkg::IDENT_LSB];
			capability_version <=
				wr_data[pb_pkg::VERSION_MSB:pb_pkg::VERSION_LSB];
			next_capability_pointer <=
				wr_data[pb_pkg::NEXT_PTR_MSB:pb_pkg::NEXT_PTR_LSB];
		end
	end

	// data select, plain read-write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_select_field <= pb_pkg::SELECT_RESET;
		end else if (wr_en && wr_addr == pb_pkg::SELECT_OFFSET) begin
			value_select_field <= wr_data[pb_pkg::SELECT_MSB:0];
		end
	end

	// system allocated flag, locked like the header
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_allocated_flag <= pb_pkg::ALLOC_RESET;
		end else if (wr_en && wr_addr == pb_pkg::ALLOC_OFFSET &&
				lock_open) begin
			system_allocated_flag <= wr_data[pb_pkg::ALLOC_FLAG_BIT];
		end
	end

	// switch control unlock bits, always writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_write_unlock  <= pb_pkg::UNLOCK_RESET;
			header_write_unlock <= pb_pkg::UNLOCK_RESET;
		end else if (wr_en && wr_addr == pb_pkg::SWITCH_CTL_OFFSET) begin
			value_write_unlock  <= wr_data[pb_pkg::VALUE_UNLOCK_BIT];
			header_write_unlock <= wr_data[pb_pkg::HEADER_UNLOCK_BIT];
		end
	end

	// indirect window onto the selected value word
	always_comb begin
		if (value_select_field <= pb_pkg::SELECT_LAST) begin
			window_data = vif.value[value_select_field[2:0]];
		end else begin
			window_data = pb_pkg::READ_ZERO;
		end
	end

	// read mux; reserved bits and unmapped offsets read zero
	always_comb begin
		next_prdata = pb_pkg::READ_ZERO;
		next_err    = 1'b0;
		if (pb_pkg::is_value_addr(paddr)) begin
			next_prdata = vif.value[pb_pkg::value_index(paddr)];
		end else begin
			unique case (paddr)
				pb_pkg::HEADER_OFFSET: begin
					next_prdata = {next_capability_pointer,
						capability_version, capability_identifier};
				end
				pb_pkg::SELECT_OFFSET: begin
					next_prdata[pb_pkg::SELECT_MSB:0] = value_select_field;
				end
				pb_pkg::WINDOW_OFFSET: begin
					next_prdata = window_data;
				end
				pb_pkg::ALLOC_OFFSET: begin
					next_prdata[pb_pkg::ALLOC_FLAG_BIT] = system_allocated_flag;
				end
				pb_pkg::SWITCH_CTL_OFFSET: begin
					next_prdata[pb_pkg::VALUE_UNLOCK_BIT]  = value_write_unlock;
					next_prdata[pb_pkg::HEADER_UNLOCK_BIT] = header_write_unlock;
				end
				default: begin
					next_err = 1'b1;
				end
			endcase
		end
	end

	// read data and error registered while selected; settled by the access
	// edge because setup always precedes access by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= pb_pkg::READ_ZERO;
			pslverr <= 1'b0;
		end else if (psel) begin
			prdata  <= pwrite ? pb_pkg::READ_ZERO : next_prdata;
			pslverr <= next_err;
		end
	end

endmodule : power_budget_regs

// [bench/power_budget_monitor.sv]
// assertions on the power budget register block ports
// assumes binding to power_budget_regs, everything on pclk
module power_budget_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        loader_we,
	input wire logic [11:0] loader_addr,
	input wire logic        system_allocated_flag,
	input wire logic        value_write_unlock
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// completed access; the loader stalls apb, so the two never collide
	wire acc = psel && penable && pready;
	wire ctl_wr = acc && pwrite && paddr == 12'h400;
	wire rd = acc && !pwrite;

	property p_flag_src;
		!$stable(system_allocated_flag) |-> $past(acc && pwrite &&
			paddr == 12'h28c || loader_we && loader_addr == 12'h28c);
	endproperty
	a_flag_src: assert property (p_flag_src)
		else $error("alloc flag moved without a write");
	property p_alloc_rd;
		rd && paddr == 12'h28c |-> prdata[31:1] == 31'h0;
	endproperty
	a_alloc_rd: assert property (p_alloc_rd)
		else $error("alloc reserved bits not zero");
	property p_sel_rd;
		rd && paddr == 12'h284 |-> prdata[31:8] == 24'h0;
	endproperty
	a_sel_rd: assert property (p_sel_rd)
		else $error("select high bits not zero");
	property p_cap_map;
		acc && paddr[11:4] == 8'h28 |-> !pslverr;
	endproperty
	a_cap_map: assert property (p_cap_map)
		else $error("capability register gave an error");
	property p_val_map;
		acc && paddr[11:5] == 7'h18 && paddr[1:0] == 2'h0 |-> !pslverr;
	endproperty
	a_val_map: assert property (p_val_map)
		else $error("value word gave an error");
	property p_unmapped;
		acc && paddr == 12'h320 |-> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("offset past the value words accepted");
	property p_unl_rise;
		$rose(value_write_unlock) |-> $past(ctl_wr && pwdata[0]);
	endproperty
	a_unl_rise: assert property (p_unl_rise)
		else $error("unlock set without a control write");
	property p_unl_fall;
		$fell(value_write_unlock) |-> $past(ctl_wr && !pwdata[0]);
	endproperty
	a_unl_fall: assert property (p_unl_fall)
		else $error("unlock cleared without a control write");
endmodule : power_budget_monitor

bind power_budget_regs power_budget_monitor mon_u (.*);

// [bench/power_budget_regs_tb.sv]
// self-checking bench for the power budget register block
// assumes a 25 MHz pclk; apb waits on pready, never on a count
module power_budget_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, loader_we = 1'b0, pready, pslverr, e;
	logic        system_allocated_flag, value_write_unlock;
	logic [11:0] paddr = 12'h0, loader_addr = 12'h0;
	logic [31:0] pwdata = 32'h0, loader_wdata = 32'h0, prdata, r;
	int          num_errors = 0, cmp_count = 0, cyc = 0;

	power_budget_regs dut_u (.*);
	always #20 pclk = ~pclk;

	task report_and_stop();
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	// hang guard, far above the roughly 150 cycles the run needs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task chk(input logic [11:0] a, input logic [31:0] x, g);
		cmp_count++;
		if (g !== x) begin
			num_errors++;
			$display("CHECK FAILED reg %h exp %h got %h", a, x, g);
		end
	endtask : chk

	// one transfer; request held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(a, x, r);
	endtask : rd

	// privileged loader word, one-cycle strobe
	task ld(input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		loader_we <= 1'b1;
		loader_addr <= a;
		loader_wdata <= d;
		@(posedge pclk);
		// the bus must be stalled while the loader strobe stands
		chk(12'h000, 32'h0, {31'h0, pready});
		loader_we <= 1'b0;
	endtask : ld

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h280, 32'h0);
		rd(12'h284, 32'h0);
		rd(12'h28c, 32'h0);
		ld(12'h280, 32'h0001_0004);
		ld(12'h28c, 32'h1);
		apb(1'b1, 12'h280, 32'hffff_ffff);
		apb(1'b1, 12'h28c, 32'h0);
		rd(12'h280, 32'h0001_0004);
		chk(12'h28c, 32'h1, {31'h0, system_allocated_flag});
		apb(1'b1, 12'h400, 32'h1);
		// each word through the window, so a wrong index shows up
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, 12'h300 + 12'(4 * i), 32'hb0d9_0000 + 32'(i));
			apb(1'b1, 12'h284, 32'(i));
			rd(12'h288, 32'hb0d9_0000 + 32'(i));
		end
		apb(1'b1, 12'h400, 32'h0);
		apb(1'b1, 12'h30c, 32'h0);
		rd(12'h30c, 32'hb0d9_0003);
		apb(1'b1, 12'h284, 32'hffff_ff08);
		rd(12'h284, 32'h8);
		rd(12'h288, 32'h0);
		apb(1'b1, 12'h284, 32'hff);
		rd(12'h288, 32'h0);
		rd(12'h320, 32'h0);
		chk(12'h320, 32'h1, {31'h0, e});
		apb(1'b1, 12'h400, 32'h2);
		apb(1'b1, 12'h28c, 32'h0);
		rd(12'h28c, 32'h0);
		// warm reset: header clears but the value words must survive
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		rd(12'h31c, 32'hb0d9_0007);
		rd(12'h280, 32'h0);
		report_and_stop();
	end
endmodule : power_budget_regs_tb
